// [hw/clc_pkg.sv]
// constants, layouts and carrier types for the configurable logic cell
// assumes a 32-bit classic wishbone master and byte addressing

package clc_pkg;
   localparam int ADR_W = 6;
   localparam int DAT_W = 32;
   localparam int N_GATE = 4;

   // register byte offsets
   localparam logic [ADR_W-1:0] CTRL_OFS = 6'h00;
   localparam logic [ADR_W-1:0] POL_OFS = 6'h04;
   localparam logic [ADR_W-1:0] SEL_OFS = 6'h08;
   localparam logic [ADR_W-1:0] GLS_OFS = 6'h18;
   localparam logic [ADR_W-1:0] MIRROR_OFS = 6'h28;
   localparam logic [ADR_W-1:0] STAT_OFS = 6'h2c;
   localparam logic [ADR_W-1:0] MASK_OFS = 6'h30;

   // field positions
   localparam int OUT_INV_BIT = 7;
   localparam int STAT_RISE_BIT = 0;
   localparam int STAT_FALL_BIT = 1;
   localparam int EV_W = 2;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [EV_W-1:0] STAT_RST = 2'h0;
   localparam logic [EV_W-1:0] MASK_RST = 2'h0;

   typedef enum logic [2:0] {
      MODE_AND_OR = 3'b000,
      MODE_OR_XOR = 3'b001,
      MODE_AND4 = 3'b010,
      MODE_SR = 3'b011,
      MODE_DFF_SR = 3'b100,
      MODE_DFF2_R = 3'b101,
      MODE_JK_R = 3'b110,
      MODE_LATCH_SR = 3'b111
   } clc_mode_t;

   typedef struct packed {
      logic en;
      logic rsv;
      logic out;
      logic rise;
      logic fall;
      clc_mode_t mode;
   } clc_ctrl_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [DAT_W-1:0] dat;
   } clc_wb_req_t;
endpackage : clc_pkg

// [hw/clc_cell.sv]
// configurable logic cell: input selectors, four gates, logic function,
// output polarity, edge-event interrupt, classic wishbone register slave
// assumes data_in is synchronous to clk and the master waits for ack
`timescale 1ns/1ps

module clc_cell #(
   parameter int SEL_W = 3
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [(1<<SEL_W)-1:0] data_in,
   input wire clc_pkg::clc_wb_req_t wb_req,
   output logic wb_ack,
   output logic [clc_pkg::DAT_W-1:0] wb_rdata,
   output logic cell_out,
   output logic irq
);
   import clc_pkg::*;

   function automatic logic gate_eval(input logic [N_GATE-1:0] d, input logic [7:0] en);
      logic acc;
      acc = 1'b0;
      for (int j = 0; j < N_GATE; j++) begin
         acc = acc | (en[2*j] & ~d[j]) | (en[2*j+1] & d[j]);
      end
      return acc;
   endfunction : gate_eval

   function automatic logic is_slot(input logic [ADR_W-1:0] a, input logic [ADR_W-1:0] base,
                                    input int k);
      return a == base + ADR_W'(4 * k);
   endfunction : is_slot

   clc_ctrl_t ctrl_reg, ctrl_next;
   logic [7:0] pol_reg, pol_next;
   logic [SEL_W-1:0] sel_reg [N_GATE];
   logic [SEL_W-1:0] sel_next [N_GATE];
   logic [7:0] gls_reg [N_GATE];
   logic [7:0] gls_next [N_GATE];
   logic [EV_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
   logic q_reg, q_next, clk_gate_reg, clk_gate_next;
   logic out_reg, out_next, irq_reg, irq_next;
   logic ack_reg, ack_next;
   logic [DAT_W-1:0] rdata_reg, rdata_next;

   logic req, wr;
   logic [N_GATE-1:0] d, g;
   logic f, gate_edge, rise_ev, fall_ev;
   logic [EV_W-1:0] ev, clr;

   assign req = wb_req.cyc & wb_req.stb;
   // writes land on the edge where the master sees ack
   assign wr = req & wb_req.we & ack_reg & wb_req.sel[0];

   // selector and gate stage
   // every gate reads all four selected inputs, so the selectors settle first
   always_comb begin
      for (int k = 0; k < N_GATE; k++) begin
         d[k] = data_in[sel_reg[k]];
      end
      for (int k = 0; k < N_GATE; k++) begin
         g[k] = gate_eval(d, gls_reg[k]) ^ pol_reg[k];
      end
   end

   // logic function and storage element; clocked modes use g[0] as clock
   always_comb begin
      q_next = q_reg;
      f = 1'b0;
      gate_edge = g[0] & ~clk_gate_reg;
      clk_gate_next = g[0];
      case (ctrl_reg.mode)
         MODE_AND_OR: f = (g[0] & g[1]) | (g[2] & g[3]);
         MODE_OR_XOR: f = (g[0] | g[1]) ^ (g[2] | g[3]);
         MODE_AND4: f = &g;
         MODE_SR: begin
            if (g[2] | g[3]) begin
               q_next = 1'b0;
            end else if (g[0] | g[1]) begin
               q_next = 1'b1;
            end
            f = q_next;
         end
         MODE_DFF_SR: begin
            if (g[2]) begin
               q_next = 1'b0;
            end else if (g[3]) begin
               q_next = 1'b1;
            end else if (gate_edge) begin
               q_next = g[1];
            end
            f = q_next;
         end
         MODE_DFF2_R: begin
            if (g[2]) begin
               q_next = 1'b0;
            end else if (gate_edge) begin
               q_next = g[1] & g[3];
            end
            f = q_next;
         end
         MODE_JK_R: begin
            if (g[2]) begin
               q_next = 1'b0;
            end else if (gate_edge) begin
               q_next = (g[1] & ~q_reg) | (~g[3] & q_reg);
            end
            f = q_next;
         end
         MODE_LATCH_SR: begin
            if (g[2]) begin
               q_next = 1'b0;
            end else if (g[3]) begin
               q_next = 1'b1;
            end else if (g[0]) begin
               q_next = g[1];
            end
            f = q_next;
         end
         default: f = 1'b0;
      endcase
      // disabled cell holds its storage cleared and its output low
      if (!ctrl_reg.en) begin
         q_next = 1'b0;
      end
      // path depends only on live inputs, settings and the stored bit of the storage modes, never on a cpu gate
      out_next = ctrl_reg.en & (f ^ pol_reg[OUT_INV_BIT]);
   end

   // edge detectors and sticky status
   always_comb begin
      rise_ev = ctrl_reg.en & ctrl_reg.rise & out_next & ~out_reg;
      fall_ev = ctrl_reg.en & ctrl_reg.fall & ~out_next & out_reg;
      ev = '0;
      ev[STAT_RISE_BIT] = rise_ev;
      ev[STAT_FALL_BIT] = fall_ev;
      clr = (wr && wb_req.adr == STAT_OFS) ? wb_req.dat[EV_W-1:0] : '0;
      // a new edge beats a clear in the same cycle
      stat_next = (stat_reg & ~clr) | ev;
      mask_next = (wr && wb_req.adr == MASK_OFS) ? wb_req.dat[EV_W-1:0] : mask_reg;
      irq_next = |(stat_next & mask_next);
   end

   // register writes
   always_comb begin
      ctrl_next = ctrl_reg;
      pol_next = pol_reg;
      for (int k = 0; k < N_GATE; k++) begin
         sel_next[k] = sel_reg[k];
         gls_next[k] = gls_reg[k];
         if (wr && is_slot(wb_req.adr, SEL_OFS, k)) begin
            sel_next[k] = wb_req.dat[SEL_W-1:0];
         end
         if (wr && is_slot(wb_req.adr, GLS_OFS, k)) begin
            gls_next[k] = wb_req.dat[7:0];
         end
      end
      if (wr && wb_req.adr == CTRL_OFS) begin
         ctrl_next = clc_ctrl_t'(wb_req.dat[7:0]);
         ctrl_next.out = 1'b0;
         ctrl_next.rsv = 1'b0;
      end
      if (wr && wb_req.adr == POL_OFS) begin
         pol_next = wb_req.dat[7:0] & 8'h8f;
      end
   end

   // bus answer: ack one cycle after a new request, read data sampled then
   always_comb begin
      clc_ctrl_t rd_ctrl;
      rd_ctrl = ctrl_reg;
      rd_ctrl.out = out_reg;
      ack_next = req & ~ack_reg;
      rdata_next = '0;
      if (ack_next && !wb_req.we) begin
         case (wb_req.adr)
            CTRL_OFS: rdata_next[7:0] = rd_ctrl;
            POL_OFS: rdata_next[7:0] = pol_reg;
            MIRROR_OFS: rdata_next[0] = out_reg;
            STAT_OFS: rdata_next[EV_W-1:0] = stat_reg;
            MASK_OFS: rdata_next[EV_W-1:0] = mask_reg;
            default: begin
               for (int k = 0; k < N_GATE; k++) begin
                  if (is_slot(wb_req.adr, SEL_OFS, k)) begin
                     rdata_next[SEL_W-1:0] = sel_reg[k];
                  end
                  if (is_slot(wb_req.adr, GLS_OFS, k)) begin
                     rdata_next[7:0] = gls_reg[k];
                  end
               end
            end
         endcase
      end
   end

   // control, status and datapath state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= clc_ctrl_t'(CTRL_RST);
         stat_reg <= STAT_RST;
         mask_reg <= MASK_RST;
         q_reg <= 1'b0;
         clk_gate_reg <= 1'b0;
         out_reg <= 1'b0;
         irq_reg <= 1'b0;
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else if (ce) begin
         ctrl_reg <= ctrl_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         q_reg <= q_next;
         clk_gate_reg <= clk_gate_next;
         out_reg <= out_next;
         irq_reg <= irq_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   // selection, gating and polarity survive any reset, so they have none
   always_ff @(posedge clk) begin
      if (ce) begin
         pol_reg <= pol_next;
         sel_reg <= sel_next;
         gls_reg <= gls_next;
      end
   end

   assign wb_ack = ack_reg;
   assign wb_rdata = rdata_reg;
   assign cell_out = out_reg;
   assign irq = irq_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_new_req;
      ce && req && !ack_reg;
   endsequence

   sequence s_ack_pulse;
      ack_reg ##1 (!ack_reg || !ce);
   endsequence

   a_ack_single_pulse:
   assert property (s_new_req |=> s_ack_pulse)
      else $error("ack not a single pulse after request");

   a_disabled_low:
   assert property (ce && !ctrl_reg.en |=> !cell_out && stat_reg == $past(stat_reg & ~clr))
      else $error("disabled cell drove output or raised event");

   a_rise_event:
   assert property (ce && ctrl_reg.en && ctrl_reg.rise && !out_reg && out_next
                    |=> stat_reg[STAT_RISE_BIT] ##0 cell_out)
      else $error("rising edge did not set flag");

   a_fall_event:
   assert property (ce && ctrl_reg.en && ctrl_reg.fall && out_reg && !out_next
                    |=> stat_reg[STAT_FALL_BIT] && !cell_out)
      else $error("falling edge did not set flag");

   a_set_wins_clear:
   assert property (ce && (rise_ev || fall_ev) && clr != '0 |=> (stat_reg & $past(ev)) != '0)
      else $error("edge lost while flag was cleared");

   a_mirror_read:
   assert property (s_new_req and (!wb_req.we && wb_req.adr == MIRROR_OFS)
                    |=> wb_ack && wb_rdata[0] == $past(out_reg))
      else $error("mirror read does not match output");

   a_and_or_func:
   assert property (ce && ctrl_reg.en && ctrl_reg.mode == MODE_AND_OR
                    |=> cell_out == $past(((g[0] & g[1]) | (g[2] & g[3])) ^ pol_reg[OUT_INV_BIT]))
      else $error("and-or function result wrong");

   a_gate_polarity:
   assert property (ce && ctrl_reg.en && ctrl_reg.mode == MODE_AND4 && !pol_reg[OUT_INV_BIT]
                    |=> cell_out == $past(&(gate_eval(d, gls_reg[0]) ^ pol_reg[0]) & g[1] & g[2] & g[3]))
      else $error("gate polarity not applied");

   a_output_invert:
   assert property (ce && ctrl_reg.en && ctrl_reg.mode == MODE_OR_XOR
                    |=> cell_out == $past(((g[0] | g[1]) ^ (g[2] | g[3])) ^ pol_reg[OUT_INV_BIT]))
      else $error("output polarity wrong");

   a_irq_level:
   assert property (irq == |(stat_reg & mask_reg))
      else $error("interrupt level does not follow status and mask");
endmodule : clc_cell

// [verification/clc_cell_tb.sv]
// self-checking bench for the configurable logic cell, random configs in all eight modes
// assumes the wishbone slave acks one cycle after a request and data_in is sync to clk
`timescale 1ns/1ps

module clc_cell_tb;
   import clc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] data_in = 8'h00;
   clc_wb_req_t wb_req = '0;
   logic wb_ack;
   logic [DAT_W-1:0] wb_rdata;
   logic cell_out;
   logic irq;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc_cnt = 0;
   logic [DAT_W-1:0] rd;
   logic [2:0] sel_v [4];
   logic [7:0] gls_v [4];
   logic [3:0] gpol;
   logic oinv;
   logic [2:0] mode;
   logic qm;
   logic g0m;

   always #2.5 clk = ~clk;

   clc_cell #(.SEL_W(3)) dut_u (
      .clk(clk), .rst_n(rst_n), .ce(ce), .data_in(data_in), .wb_req(wb_req),
      .wb_ack(wb_ack), .wb_rdata(wb_rdata), .cell_out(cell_out), .irq(irq));

   task automatic wrap_up();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // hold the request until ack is sampled high, then release
   task automatic wb_cycle(input logic we, input logic [5:0] adr, input logic [31:0] dat);
      int t;
      t = 0;
      @(posedge clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
      do begin
         @(posedge clk);
         t++;
      end while (wb_ack !== 1'b1 && t < 50);
      if (t >= 50) check("ack", 32'h0, 32'h1);
      rd = wb_rdata;
      wb_req <= '0;
   endtask : wb_cycle

   task automatic rd_chk(input string what, input logic [5:0] adr, input logic [31:0] exp);
      wb_cycle(1'b0, adr, 32'h0);
      check(what, rd, exp);
   endtask : rd_chk

   function automatic logic [3:0] exp_gates(input logic [7:0] d);
      logic [3:0] g;
      logic [3:0] x;
      for (int i = 0; i < 4; i++) begin
         x[i] = d[sel_v[i]];
      end
      for (int j = 0; j < 4; j++) begin
         g[j] = 1'b0;
         for (int i = 0; i < 4; i++) begin
            g[j] |= (gls_v[j][2*i] & ~x[i]) | (gls_v[j][2*i+1] & x[i]);
         end
         g[j] ^= gpol[j];
      end
      return g;
   endfunction : exp_gates

   // one call per input change; storage modes keep state in qm, clock edge is g0 rising vs g0m
   function automatic logic exp_out(input logic [7:0] d);
      logic [3:0] g;
      logic r;
      logic edg;
      g = exp_gates(d);
      edg = g[0] & ~g0m;
      case (mode)
         3'd0: r = (g[0] & g[1]) | (g[2] & g[3]);
         3'd1: r = (g[0] | g[1]) ^ (g[2] | g[3]);
         3'd2: r = &g;
         3'd3: r = (g[2] | g[3]) ? 1'b0 : ((g[0] | g[1]) ? 1'b1 : qm);
         3'd4: r = g[2] ? 1'b0 : (g[3] ? 1'b1 : (edg ? g[1] : qm));
         3'd5: r = g[2] ? 1'b0 : (edg ? (g[1] & g[3]) : qm);
         3'd6: r = g[2] ? 1'b0 : (edg ? ((g[1] & ~qm) | (~g[3] & qm)) : qm);
         default: r = g[2] ? 1'b0 : (g[3] ? 1'b1 : (g[0] ? g[1] : qm));
      endcase
      qm = r;
      g0m = g[0];
      return r ^ oinv;
   endfunction : exp_out

   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt > 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   initial begin
      logic old;
      logic nw;
      logic [1:0] st;
      logic [1:0] mk;
      logic [1:0] rf;
      logic [7:0] ctl;
      logic [3:0] gq;
      rd = $urandom(32'h4215fe0b);
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("ctrl", CTRL_OFS, 32'h0);
      rd_chk("stat", STAT_OFS, 32'h0);
      rd_chk("mask", MASK_OFS, 32'h0);
      rd_chk("unmapped", 6'h3c, 32'h0);
      for (int p = 0; p < 10; p++) begin
         mode = 3'(p % 8);
         oinv = 1'($urandom);
         gpol = 4'($urandom);
         mk = 2'($urandom);
         rf = (p < 3) ? 2'(p + 1) : 2'($urandom);
         wb_cycle(1'b1, CTRL_OFS, 32'h0);
         for (int j = 0; j < 4; j++) begin
            sel_v[j] = 3'($urandom);
            gls_v[j] = 8'($urandom);
            wb_cycle(1'b1, SEL_OFS + 6'(4 * j), {29'h0, sel_v[j]});
            wb_cycle(1'b1, GLS_OFS + 6'(4 * j), {24'h0, gls_v[j]});
         end
         wb_cycle(1'b1, POL_OFS, {24'h0, oinv, 3'h0, gpol});
         wb_cycle(1'b1, MASK_OFS, {30'h0, mk});
         wb_cycle(1'b1, STAT_OFS, 32'h3);
         // a disabled cell must stay low and quiet whatever its inputs do
         repeat (3) begin
            @(posedge clk);
            data_in <= 8'($urandom);
            repeat (2) @(posedge clk);
            check("out_off", {31'h0, cell_out}, 32'h0);
         end
         rd_chk("stat_off", STAT_OFS, 32'h0);
         ctl = {1'b1, 2'b00, rf, mode};
         wb_cycle(1'b1, CTRL_OFS, {24'h0, ctl});
         // the enabling edge itself may count as an event, so start from a clean status
         wb_cycle(1'b1, STAT_OFS, 32'h3);
         st = 2'h0;
         // storage starts cleared and the inputs have been steady since the enable
         qm = 1'b0;
         gq = exp_gates(data_in);
         g0m = gq[0];
         old = exp_out(data_in);
         for (int k = 0; k < 12; k++) begin
            @(posedge clk);
            data_in <= (k == 0) ? ~data_in : 8'($urandom);
            repeat (2) @(posedge clk);
            nw = exp_out(data_in);
            check("cell_out", {31'h0, cell_out}, {31'h0, nw});
            if (!old && nw && rf[1]) st[STAT_RISE_BIT] = 1'b1;
            if (old && !nw && rf[0]) st[STAT_FALL_BIT] = 1'b1;
            check("irq", {31'h0, irq}, {31'h0, |(st & mk)});
            old = nw;
         end
         ctl[5] = old;
         rd_chk("ctrl_rb", CTRL_OFS, {24'h0, ctl});
         rd_chk("mirror", MIRROR_OFS, {31'h0, old});
         rd_chk("stat_ev", STAT_OFS, {30'h0, st});
         wb_cycle(1'b1, STAT_OFS, 32'h1);
         rd_chk("stat_clr", STAT_OFS, {30'h0, st & 2'b10});
      end
      // corner: output follows data_in[0]; a clear of the rise flag races a new rising edge
      mode = 3'd2;
      oinv = 1'b0;
      gpol = 4'h0;
      wb_cycle(1'b1, CTRL_OFS, 32'h0);
      for (int j = 0; j < 4; j++) begin
         sel_v[j] = 3'h0;
         gls_v[j] = 8'h02;
         wb_cycle(1'b1, SEL_OFS + 6'(4 * j), 32'h0);
         wb_cycle(1'b1, GLS_OFS + 6'(4 * j), 32'h2);
      end
      wb_cycle(1'b1, POL_OFS, 32'h0);
      wb_cycle(1'b1, MASK_OFS, 32'h3);
      data_in <= 8'h00;
      wb_cycle(1'b1, CTRL_OFS, 32'h9a);
      wb_cycle(1'b1, STAT_OFS, 32'h3);
      data_in <= 8'h01;
      repeat (2) @(posedge clk);
      data_in <= 8'h00;
      repeat (2) @(posedge clk);
      check("out_low", {31'h0, cell_out}, 32'h0);
      fork
         wb_cycle(1'b1, STAT_OFS, 32'h1);
         begin
            // the edge that samples the request launches the new input, so the event hits the ack cycle
            do begin
               @(posedge clk);
            end while (!(wb_req.cyc && wb_ack === 1'b0));
            data_in <= 8'h01;
         end
      join
      rd_chk("stat_race", STAT_OFS, 32'h3);
      check("irq_race", {31'h0, irq}, 32'h1);
      check("out_race", {31'h0, cell_out}, 32'h1);
      wb_cycle(1'b1, STAT_OFS, 32'h3);
      // ce low freezes the cell: the falling input must not reach the output yet
      ce <= 1'b0;
      data_in <= 8'h00;
      repeat (3) @(posedge clk);
      check("ce_hold", {31'h0, cell_out}, 32'h1);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      check("ce_run", {31'h0, cell_out}, 32'h0);
      rd_chk("stat_ce", STAT_OFS, 32'h2);
      // reset in mid-run: control cleared, selection and gating kept
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      check("out_rst", {31'h0, cell_out}, 32'h0);
      rd_chk("ctrl_rst", CTRL_OFS, 32'h0);
      for (int j = 0; j < 4; j++) begin
         rd_chk("sel_kept", SEL_OFS + 6'(4 * j), {29'h0, sel_v[j]});
         rd_chk("gls_kept", GLS_OFS + 6'(4 * j), {24'h0, gls_v[j]});
      end
      rd_chk("pol_kept", POL_OFS, {24'h0, oinv, 3'h0, gpol});
      wrap_up();
   end
endmodule : clc_cell_tb
